/* File: core/adc_mode_cfg.svh */
// Register map, field positions and reset values for the mode control bank
`ifndef ADC_MODE_CFG_SVH
`define ADC_MODE_CFG_SVH
`define ADDR_SOFT_RESET   7'h00
`define ADDR_FORMAT_POWER 7'h01
`define ADDR_OUTPUT_CFG   7'h02
`define ADDR_PATTERN_HIGH 7'h03
`define ADDR_PATTERN_LOW  7'h04
`define REG_RESET_VALUE   8'h00
`define WORD_BITS         5'h10
`define ADDR_BITS_DONE    5'h08
`define CHANNEL_COUNT     2
`define SOFT_RESET_BIT    7
`define FMT_DCS_OFF_BIT   7
`define FMT_SCRAMBLE_BIT  6
`define FMT_SIGNED_BIT    5
`define FMT_SLEEP_BIT     4
`define FMT_NAP_B_BIT     3
`define FMT_NAP_A_BIT     0
`define FMT_VALID_MASK    8'hF9
`define OUT_VALID_MASK    8'hFF
`define PAT_HIGH_MASK     8'hBF
`define PAT_FORCE_BIT     7
`define OUT_TERM_BIT      4
`define OUT_DISABLE_BIT   3
`define CUR_UNUSED_CODE   3'h3
`define LANE_UNUSED_A     3'h3
`define LANE_UNUSED_B     3'h4
`define SLEEP_HOLD_CYCLES 3'h4
`endif

/* File: core/adc_mode_pkg.sv */
// Types shared by the mode control bank
package adc_mode_pkg;
  typedef struct packed {
    logic       duty_stabilizer_disable;
    logic       output_scramble_enable;
    logic       signed_format_select;
    logic       sleep_all;
    logic       nap_b;
    logic       nap_a;
    logic [2:0] driver_current_select;
    logic       internal_term_enable;
    logic       outputs_disable;
    logic [2:0] lane_width_select;
    logic       pattern_force_enable;
    logic [13:0] pattern_bits;
  } mode_ctrl_t;
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_cmd_t;
  typedef enum logic [1:0] {
    RST_IDLE  = 2'b00,
    RST_SLEEP = 2'b01,
    RST_DONE  = 2'b10
  } rst_state_t;
endpackage : adc_mode_pkg

/* File: core/adc_mode_control_registers.sv */
// Serial mode control register bank with output data formatting
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Writing D7 of reset register clears registers
// - Converter briefly slept during software reset
// - Software reset bit clears itself when done
// - Reset register low seven bits ignored
// - Format bit 7 turns duty stabilizer off
// - Bits 7-5 select driver current, 011 unused
// - Bit 4 enables termination, doubles current
// - Bit 3 only sets mode.outputs_disable; data_a, data_b and sdo keep driving
// - Bits 2-0 select lanes and serialization width
// - Pattern high bit 7 forces pattern, bit 6 ignored
// - Pattern high bits 5-0 give data 13-8
// - Pattern low bits give data 7-0
// - Sixteen-bit serial word: flag, address, data
// - Scramble XORs LSB into other data bits
// - Signed bit selects two's complement coding
// - Test pattern overrides coding and scrambling
`timescale 1ns/100ps
`include "adc_mode_cfg.svh"
module adc_mode_control_registers (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  input  wire logic                    sdi,
  output logic                         sdo_out,
  output logic                         sdo_oe_n,
  input  wire logic [13:0]             sample_a,
  input  wire logic [13:0]             sample_b,
  output logic      [13:0]             data_a,
  output logic      [13:0]             data_b,
  output adc_mode_pkg::mode_ctrl_t     mode,
  output logic                         soft_reset_busy
);

  //////////////////////////////////////////////////////////////////////////
  // Serial shift logic on the serial clock
  logic [15:0]              shift;
  logic [4:0]               bit_count;
  logic                     word_toggle;
  adc_mode_pkg::spi_cmd_t   cmd_word;
  logic [7:0]               read_data;
  logic [7:0]               read_shift;
  logic                     read_active;
  logic                     addr_done;
  logic                     read_frame;
  logic                     last_edge;

  // Eight edges in, the flag bit sits at the top of the address byte
  assign addr_done  = (bit_count == `ADDR_BITS_DONE);
  assign read_frame = addr_done && shift[7];
  // The sixteenth bit is still on sdi, so the word is built from both
  assign last_edge  = !cs_n && (bit_count == `WORD_BITS - 5'h01);

  // Chip select high clears the framing; SCK may stop between words
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_count <= 5'h00;
      shift     <= 16'h0000;
    end else if (bit_count != `WORD_BITS) begin
      shift     <= {shift[14:0], sdi};
      bit_count <= bit_count + 5'h01;
    end
  end

  // Word hand-off by toggle; the captured word is stable until the next frame
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      word_toggle <= 1'b0;
      cmd_word    <= '0;
    end else if (last_edge) begin
      word_toggle <= ~word_toggle;
      cmd_word    <= {~shift[14], shift[13:7], shift[6:0], sdi};
    end
  end

  // Readback shifts out on falling SCK after the address byte
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      read_shift  <= 8'h00;
      read_active <= 1'b0;
    end else if (read_frame) begin
      // D7 is already on the pin; the next falling edge brings D6 up
      read_shift  <= read_data;
      read_active <= 1'b1;
    end else begin
      read_shift  <= {read_shift[6:0], 1'b0};
    end
  end

  // Open drain: enable low pulls the pin to ground
  always_comb begin
    sdo_out  = 1'b0;
    sdo_oe_n = 1'b1;
    if (!cs_n && read_frame) begin
      sdo_oe_n = read_data[7];
    end else if (read_active && !cs_n) begin
      sdo_oe_n = read_shift[7];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossing into the mclk domain
  logic [2:0] toggle_sync;
  logic       word_strobe;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_sync <= 3'h0;
    end else begin
      toggle_sync <= {toggle_sync[1:0], word_toggle};
    end
  end
  assign word_strobe = toggle_sync[2] ^ toggle_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]               format_power_reg;
  logic [7:0]               output_config_reg;
  logic [7:0]               pattern_high_reg;
  logic [7:0]               pattern_low_reg;
  logic                     soft_reset_reg;
  adc_mode_pkg::rst_state_t rst_state;
  logic [2:0]               sleep_count;
  logic                     clear_all;
  logic                     reset_request;

  function automatic logic is_write(input logic [6:0] a);
    is_write = word_strobe && cmd_word.write && cmd_word.addr == a;
  endfunction : is_write

  assign clear_all = (rst_state == adc_mode_pkg::RST_DONE);
  // Only D7 counts; the low seven bits of the reset register are don't-care
  assign reset_request = is_write(`ADDR_SOFT_RESET) && cmd_word.data[`SOFT_RESET_BIT];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      format_power_reg  <= `REG_RESET_VALUE;
      output_config_reg <= `REG_RESET_VALUE;
      pattern_high_reg  <= `REG_RESET_VALUE;
      pattern_low_reg   <= `REG_RESET_VALUE;
    end else if (clear_all) begin
      format_power_reg  <= `REG_RESET_VALUE;
      output_config_reg <= `REG_RESET_VALUE;
      pattern_high_reg  <= `REG_RESET_VALUE;
      pattern_low_reg   <= `REG_RESET_VALUE;
    end else begin
      // Unused bits are never stored so they read back as zero
      if (is_write(`ADDR_FORMAT_POWER)) begin
        format_power_reg <= cmd_word.data & `FMT_VALID_MASK;
      end
      if (is_write(`ADDR_OUTPUT_CFG)) begin
        output_config_reg <= cmd_word.data & `OUT_VALID_MASK;
      end
      if (is_write(`ADDR_PATTERN_HIGH)) begin
        pattern_high_reg <= cmd_word.data & `PAT_HIGH_MASK;
      end
      if (is_write(`ADDR_PATTERN_LOW)) begin
        pattern_low_reg <= cmd_word.data;
      end
    end
  end

  // Software reset sequencer: sleep a few cycles, clear, release the bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_state      <= adc_mode_pkg::RST_IDLE;
      sleep_count    <= 3'h0;
      soft_reset_reg <= 1'b0;
    end else begin
      case (rst_state)
        adc_mode_pkg::RST_IDLE: begin
          if (reset_request) begin
            rst_state      <= adc_mode_pkg::RST_SLEEP;
            soft_reset_reg <= 1'b1;
            sleep_count    <= 3'h0;
          end
        end
        adc_mode_pkg::RST_SLEEP: begin
          sleep_count <= sleep_count + 3'h1;
          if (sleep_count == `SLEEP_HOLD_CYCLES - 3'h1) begin
            rst_state <= adc_mode_pkg::RST_DONE;
          end
        end
        adc_mode_pkg::RST_DONE: begin
          rst_state      <= adc_mode_pkg::RST_IDLE;
          soft_reset_reg <= 1'b0;
        end
        default: begin
          rst_state <= adc_mode_pkg::RST_IDLE;
        end
      endcase
    end
  end

  assign soft_reset_busy = soft_reset_reg;

  // Readback decode; unmapped addresses return zero
  function automatic logic [7:0] read_value(input logic [6:0] a);
    case (a)
      `ADDR_SOFT_RESET:   read_value = {soft_reset_reg, 7'h00};
      `ADDR_FORMAT_POWER: read_value = format_power_reg;
      `ADDR_OUTPUT_CFG:   read_value = output_config_reg;
      `ADDR_PATTERN_HIGH: read_value = pattern_high_reg;
      `ADDR_PATTERN_LOW:  read_value = pattern_low_reg;
      default:            read_value = `REG_RESET_VALUE;
    endcase
  endfunction : read_value

  // Read in the serial domain straight from the mclk registers; they hold
  // still during a read frame since a read never writes and words are spaced
  always_comb begin
    read_data = read_value(shift[6:0]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    mode.duty_stabilizer_disable = format_power_reg[`FMT_DCS_OFF_BIT];
    mode.output_scramble_enable  = format_power_reg[`FMT_SCRAMBLE_BIT];
    mode.signed_format_select    = format_power_reg[`FMT_SIGNED_BIT];
    mode.sleep_all = format_power_reg[`FMT_SLEEP_BIT] | soft_reset_reg;
    mode.nap_b     = format_power_reg[`FMT_NAP_B_BIT];
    mode.nap_a     = format_power_reg[`FMT_NAP_A_BIT];
    mode.driver_current_select = output_config_reg[7:5];
    mode.internal_term_enable  = output_config_reg[`OUT_TERM_BIT];
    mode.outputs_disable       = output_config_reg[`OUT_DISABLE_BIT];
    mode.lane_width_select     = output_config_reg[2:0];
    mode.pattern_force_enable  = pattern_high_reg[`PAT_FORCE_BIT];
    mode.pattern_bits = {pattern_high_reg[5:0], pattern_low_reg};
  end

  //////////////////////////////////////////////////////////////////////////
  // Output data formatting
  function automatic logic [13:0] format_sample(input logic [13:0] s,
                                                input adc_mode_pkg::mode_ctrl_t m);
    logic [13:0] v;
    v = s;
    if (m.signed_format_select) begin
      v[13] = ~v[13];
    end
    if (m.output_scramble_enable) begin
      v[13:1] = v[13:1] ^ {13{v[0]}};
    end
    if (m.pattern_force_enable) begin
      v = m.pattern_bits;
    end
    format_sample = v;
  endfunction : format_sample

  // Both channels share one formatting path; only the power-down bit differs
  logic [13:0] raw_sample [`CHANNEL_COUNT];
  logic [1:0]  chan_off;

  assign raw_sample[0] = sample_a;
  assign raw_sample[1] = sample_b;
  assign chan_off      = {mode.sleep_all | mode.nap_b, mode.sleep_all | mode.nap_a};

  genvar ch;
  generate
    for (ch = 0; ch < `CHANNEL_COUNT; ch++) begin : g_chan
      logic [13:0] q;
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          q <= 14'h0000;
        end else begin
          q <= chan_off[ch] ? 14'h0000 : format_sample(raw_sample[ch], mode);
        end
      end
    end
  endgenerate

  assign data_a = g_chan[0].q;
  assign data_b = g_chan[1].q;

endmodule : adc_mode_control_registers

/* File: verification/spi_host_model.sv */
// Host model that drives the serial configuration port
`timescale 1ns/100ps
module spi_host_model (
  output logic     sck,
  output logic     cs_n,
  output logic     sdi,
  input wire logic sdo_line
);
  // The serial clock stands still low between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input adc_mode_pkg::spi_cmd_t cmd, output logic [7:0] rd);
    logic [15:0] w;
    w = {~cmd.write, cmd.addr, cmd.data};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #3;
      // Sample before the edge so the design's own update cannot race the read
      if (i < 8) rd[i] = sdo_line;
      sck = 1'b1;
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    // A released line must not keep looking like the last bit
    sdi = ~sdi;
  endtask : xfer
endmodule : spi_host_model

/* File: verification/adc_mode_control_registers_properties.sv */
// Port checks for the mode control register bank
`timescale 1ns/100ps
module adc_mode_control_registers_properties (
  input wire logic                     mclk,
  input wire logic                     reset_n,
  input wire logic                     cs_n,
  input wire logic                     sdo_oe_n,
  input wire logic [13:0]              sample_a,
  input wire logic [13:0]              data_a,
  input wire logic [13:0]              data_b,
  input wire adc_mode_pkg::mode_ctrl_t mode,
  input wire logic                     soft_reset_busy
);
  logic run_a;
  // Pattern and power-down win, so coding is judged only without them
  assign run_a = !mode.sleep_all && !mode.nap_a && !mode.pattern_force_enable;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  pattern_drive_a: assert property (
    mode.pattern_force_enable && !mode.sleep_all && !mode.nap_a
    |=> data_a == $past(mode.pattern_bits)) else $error("Pattern lost");
  signed_code_a: assert property (
    run_a && mode.signed_format_select && !mode.output_scramble_enable
    |=> data_a == ($past(sample_a) ^ 14'h2000)) else $error("Signed code");
  sleep_zero_a: assert property (
    mode.sleep_all |=> data_a == 14'h0000 && data_b == 14'h0000) else $error("Sleep data");
  nap_zero_a: assert property (
    mode.nap_b |=> data_b == 14'h0000) else $error("Nap data");
  reset_sleep_a: assert property (
    soft_reset_busy |-> mode.sleep_all) else $error("Reset awake");
  reset_ends_a: assert property (
    $rose(soft_reset_busy) |-> ##[1:8] !soft_reset_busy) else $error("Reset stuck");
  reset_clears_a: assert property (
    $fell(soft_reset_busy) |-> ##[0:1] mode == '0) else $error("Reset left state");
  sdo_release_a: assert property (
    cs_n && $past(cs_n) |-> sdo_oe_n) else $error("Idle drive");
  pattern_c: cover property (mode.pattern_force_enable);
  reset_c: cover property ($rose(soft_reset_busy));
  readback_c: cover property (!sdo_oe_n);
endmodule : adc_mode_control_registers_properties
bind adc_mode_control_registers adc_mode_control_registers_properties props (
  .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sdo_oe_n(sdo_oe_n), .sample_a(sample_a),
  .data_a(data_a), .data_b(data_b), .mode(mode), .soft_reset_busy(soft_reset_busy));

/* File: verification/adc_mode_control_registers_tb_top.sv */
// Self-checking bench for the mode control register bank
`timescale 1ns/100ps
module adc_mode_control_registers_tb_top;
  logic                     mclk, reset_n, sck, cs_n, sdi, sdo_out, sdo_oe_n, busy;
  logic [13:0]              sample_a, sample_b, data_a, data_b;
  adc_mode_pkg::mode_ctrl_t mode;
  int                       errors, n_compared;
  adc_mode_control_registers dut (.mclk(mclk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .sample_a(sample_a),
    .sample_b(sample_b), .data_a(data_a), .data_b(data_b), .mode(mode), .soft_reset_busy(busy));
  // Pull-up on the open-drain return line
  spi_host_model host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_oe_n | sdo_out));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Reads carry the expected value in the ignored data field
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    @(posedge mclk) #1;
    host.xfer('{write: w, addr: a, data: d}, q);
    if (!w) check(16'(q), 16'(d));
    // Five cycles clears the crossing yet still sees a reset in progress
    repeat (5) @(posedge mclk);
    #1;
  endtask : xfer
  task automatic wait_busy(input logic lvl);
    for (int n = 0; busy !== lvl; n++) begin
      if (n == 40) begin
        errors++;
        print_verdict();
      end
      @(posedge mclk) #1;
    end
  endtask : wait_busy
  task automatic soft_reset;
    xfer(1'b1, 7'h00, 8'h80);
    wait_busy(1'b1);
    check(16'(mode.sleep_all), 16'h0001);
    wait_busy(1'b0);
    @(posedge mclk) #1;
    check(16'(mode === '0), 16'h0001);
    xfer(1'b0, 7'h00, 8'h00);
  endtask : soft_reset
  task automatic t_map;
    xfer(1'b1, 7'h01, 8'h7F);
    xfer(1'b0, 7'h01, 8'h79);
    check(16'(mode.duty_stabilizer_disable), 16'h0000);
    xfer(1'b1, 7'h00, 8'h7F);
    check(16'(busy), 16'h0000);
    xfer(1'b0, 7'h00, 8'h00);
    xfer(1'b1, 7'h05, 8'hAA);
    xfer(1'b0, 7'h05, 8'h00);
    xfer(1'b1, 7'h02, 8'h08);
    check(16'(mode.outputs_disable), 16'h0001);
    soft_reset();
    for (int a = 0; a < 5; a++) xfer(1'b0, 7'(a), 8'h00);
  endtask : t_map
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 7'h02, {3'(i), i >= 5, 1'b0, 3'(7 - i)});
      check(16'(mode.driver_current_select), 16'(i));
      check(16'(mode.lane_width_select), 16'(7 - i));
      check(16'(mode.internal_term_enable), 16'(i >= 5));
    end
  endtask : t_codes
  task automatic t_format;
    xfer(1'b1, 7'h01, 8'h20);
    check(16'(data_a), 16'(sample_a ^ 14'h2000));
    xfer(1'b1, 7'h01, 8'h40);
    check(16'(data_a), 16'(sample_a ^ {{13{sample_a[0]}}, 1'b0}));
    xfer(1'b1, 7'h01, 8'h80);
    check(16'(mode.duty_stabilizer_disable), 16'h0001);
    xfer(1'b1, 7'h01, 8'h09);
    check(16'(data_a | data_b), 16'h0000);
  endtask : t_format
  task automatic t_pattern;
    xfer(1'b1, 7'h01, 8'h60);
    xfer(1'b1, 7'h03, 8'hFF);
    xfer(1'b1, 7'h04, 8'h5A);
    xfer(1'b0, 7'h03, 8'hBF);
    check(16'(data_a), 16'h3F5A);
    check(16'(data_b), 16'h3F5A);
    xfer(1'b1, 7'h01, 8'h00);
    xfer(1'b1, 7'h03, 8'h15);
    check(16'(data_a), 16'(sample_a));
  endtask : t_pattern
  initial begin
    errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    sample_a = 14'h0A5B;
    sample_b = 14'h1234;
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    soft_reset();
    t_map();
    t_codes();
    t_format();
    t_pattern();
    print_verdict();
  end
endmodule : adc_mode_control_registers_tb_top
